// ---- include/hop_pkg.sv ----
// Operation
// - Frames arrive MSB first; first bit ends up at frame bit 39.
// - Strobe comes with the LSB and closes one 40-bit frame.
// - Bit 39 picks the RF path: 0 is A, 1 is B.
// - Bit 38 zero: apply the index right after the frame.
// - Bit 38 one: hold the index until the next instrument trigger of the frame's path (A or B).
// - Bits 31 to 0 are the list index to apply.
// - List mode and sweep never run together; enabling one stops the other.
// - On activation use stored settings, else learn them first.
// - Learning with short dwell may overrun first pass; report it, then honour dwell.
// - Auto, single, step walk the list in order; hop modes jump to index.
// - One edge polarity setting serves both instrument triggers.
// - In triggered hop the trigger of the frame's path applies the index; step lasts until next trigger.
package hop_pkg;

    localparam int unsigned FRAME_W    = 40;
    localparam int unsigned PATH_BIT   = 39;
    localparam int unsigned IMM_N_BIT  = 38;
    localparam int unsigned CMD_HI     = 37;
    localparam int unsigned CMD_LO     = 32;
    localparam int unsigned INDEX_W    = 32;
    localparam logic [5:0]  CMD_LIST   = 6'h01;

    // APB register byte addresses
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_LEN    = 8'h04;
    localparam logic [7:0] ADDR_DWELL  = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_IRQ    = 8'h10;
    localparam logic [7:0] ADDR_MASK   = 8'h14;
    localparam logic [7:0] ADDR_INDEX  = 8'h18;
    localparam logic [7:0] ADDR_LEARN  = 8'h1C;

    // Control register fields
    localparam int unsigned CTRL_LIST_EN  = 0;
    localparam int unsigned CTRL_SWEEP_EN = 1;
    localparam int unsigned CTRL_MODE_LO  = 4;
    localparam int unsigned CTRL_TRIG_POL = 8;
    localparam int unsigned CTRL_STEP_GO  = 9;
    localparam int unsigned CTRL_RESTART  = 10;
    localparam int unsigned CTRL_LEARN    = 11;

    // Event bits, same layout in irq, mask
    localparam int unsigned EV_APPLY   = 0;
    localparam int unsigned EV_BADCMD  = 1;
    localparam int unsigned EV_RANGE   = 2;
    localparam int unsigned EV_DWELL   = 3;
    localparam int unsigned EV_LEARNED = 4;
    localparam int unsigned EV_W       = 5;

    localparam logic [INDEX_W-1:0] LEN_RESET   = 32'h0000_0010;
    localparam logic [INDEX_W-1:0] DWELL_RESET = 32'h0000_0064;

    typedef enum logic [2:0] {
        MODE_AUTO, MODE_SINGLE, MODE_STEP, MODE_EXT_SINGLE,
        MODE_EXT_STEP, MODE_EXT_HOP, MODE_EXT_HOP_DIRECT
    } list_mode_t;

    typedef enum { ST_IDLE, ST_LEARN, ST_RUN } run_state_t;

    typedef struct packed {
        logic               path_b;
        logic               imm_n;
        logic [5:0]         cmd;
        logic [INDEX_W-1:0] index;
    } hop_frame_t;

    typedef struct packed {
        logic               valid;
        logic               path_b;
        logic [INDEX_W-1:0] index;
    } hop_apply_t;

endpackage : hop_pkg

// ---- tb/hop_link_model.sv ----
`timescale 1ns/1ps
module hop_link_model #(
    parameter int HALF = 200
) (
    // Link pins
    output logic link_clk,
    output logic link_strobe,
    output logic link_data
);
    initial begin
        link_clk = 1'b0;
        link_strobe = 1'b0;
        link_data = 1'b0;
    end

    task automatic send_frame(input logic [39:0] f);
        // Idle gap so the previous release never lands on the first bit
        #(HALF);
        for (int i = 39; i >= 0; i--) begin
            link_clk = 1'b0;
            link_data = f[i];
            link_strobe = (i == 0);
            #(HALF);
            link_clk = 1'b1;
            if (i > 0) #(HALF);
        end
        // Released data inverts so a stale bit never reads as valid
        fork
            begin
                #(HALF);
                link_clk = 1'b0;
                link_strobe = 1'b0;
                link_data = ~f[0];
            end
        join_none
    endtask : send_frame
endmodule : hop_link_model

// ---- tb/hop_receiver_checker.sv ----
`timescale 1ns/1ps
module hop_receiver_checker
    import hop_pkg::*;
(
    // Clock and reset
    input wire logic        mclk,
    input wire logic        srst,
    // APB slave
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Link and triggers
    input wire logic        link_clk,
    input wire logic        link_strobe,
    input wire logic        link_data,
    input wire logic        instrument_trigger_a,
    input wire logic        instrument_trigger_b,
    // Results
    input wire hop_apply_t  apply_q,
    input wire logic        list_active,
    input wire logic        sweep_active,
    input wire logic        irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    sequence access;
        psel && penable;
    endsequence
    sequence ctrl_write;
        access ##0 (pwrite && paddr == ADDR_CTRL);
    endsequence

    chk_modes_excl: assert property (!(list_active && sweep_active))
        else $error("list and sweep both active");
    chk_list_wins: assert property (ctrl_write ##0 pwdata[0] |-> ##[1:2] (list_active && !sweep_active))
        else $error("list enable did not stop sweep");
    chk_sweep_wins: assert property (ctrl_write ##0 (pwdata[1:0] == 2'b10) |-> ##[1:2] (sweep_active && !list_active))
        else $error("sweep enable did not stop list");
    chk_apply_pulse: assert property (apply_q.valid |=> !apply_q.valid)
        else $error("apply strobe longer than one cycle");
    chk_apply_list: assert property (apply_q.valid |-> list_active)
        else $error("apply without list running");
    chk_no_sweep_hop: assert property (sweep_active |-> !apply_q.valid)
        else $error("apply during sweep");
    chk_index_hold: assert property (!apply_q.valid |-> $stable({apply_q.path_b, apply_q.index}))
        else $error("applied index moved without apply");
    chk_ready_now: assert property (access |-> pready)
        else $error("pready low in access");
    chk_unmapped_err: assert property (access ##0 (paddr > ADDR_LEARN) |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    chk_mapped_ok: assert property (access ##0 (paddr <= ADDR_LEARN && paddr[1:0] == 2'b00) |-> !pslverr)
        else $error("mapped access refused");
endmodule : hop_receiver_checker

bind hop_receiver hop_receiver_checker chk_i (.mclk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .link_clk, .link_strobe, .link_data, .instrument_trigger_a,
    .instrument_trigger_b, .apply_q, .list_active, .sweep_active, .irq);

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top
    import hop_pkg::*;
;
    logic        mclk, srst, psel, penable, pwrite, pready, pslverr, slv, got;
    logic        instrument_trigger_a, instrument_trigger_b, list_active, sweep_active, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    wire         link_clk, link_strobe, link_data;
    hop_apply_t  apply_q, seen;
    int          fail_count = 0, tests_run = 0, cyc = 0;
    logic [5:0]  bad_cmd [3] = '{6'h03, 6'h21, CMD_LIST};

    hop_receiver dut (.mclk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .link_clk, .link_strobe, .link_data, .instrument_trigger_a, .instrument_trigger_b, .apply_q,
        .list_active, .sweep_active, .irq);
    hop_link_model link (.link_clk, .link_strobe, .link_data);

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : print_verdict

    // Hang guard, well above the few thousand cycles the run needs
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fail_count++;
            print_verdict();
        end
    end

    task automatic check(input string what, input logic [39:0] s, input logic [39:0] e);
        tests_run++;
        if (s !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, e, s);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(what, rd, e);
    endtask : rd_chk

    task automatic wait_apply(input int lim);
        got = 1'b0;
        for (int n = 0; n < lim && !got; n++) begin
            @(negedge mclk);
            if (apply_q.valid === 1'b1) begin
                got = 1'b1;
                seen = apply_q;
            end
        end
    endtask : wait_apply

    // Path, mode, command code, index
    function automatic logic [39:0] frame(input logic p, input logic im, input logic [5:0] c,
                                          input logic [31:0] idx);
        return {p, im, c, idx};
    endfunction : frame

    task automatic hop(input logic [39:0] f, input int lim);
        link.send_frame(f);
        wait_apply(lim);
    endtask : hop

    initial begin
        {srst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
        {instrument_trigger_a, instrument_trigger_b} = 2'b00;
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        check("irq", irq, 1'b0);
        rd_chk("ctrl", ADDR_CTRL, 32'h0);
        rd_chk("len", ADDR_LEN, 32'h10);
        rd_chk("dwell", ADDR_DWELL, 32'h64);
        rd_chk("unmapped", 8'h20, 32'h0);
        check("slverr", slv, 1'b1);
        apb(1'b1, ADDR_DWELL, 32'h4);
        apb(1'b1, ADDR_MASK, 32'h1F);
        apb(1'b1, ADDR_CTRL, 32'h63);
        repeat (4) @(negedge mclk);
        check("modes", {list_active, sweep_active}, 2'b10);
        check("irq", irq, 1'b1);
        rd_chk("learned", ADDR_LEARN, 32'h1);
        rd_chk("events", ADDR_IRQ, 32'h18);
        apb(1'b1, ADDR_CTRL, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h61);
        rd_chk("events", ADDR_IRQ, 32'h0);
        hop(frame(1'b1, 1'b0, CMD_LIST, 32'h5), 20);
        check("hop", {got, seen.path_b, seen.index}, {2'b11, 32'h5});
        hop(frame(1'b0, 1'b0, CMD_LIST, 32'hF), 20);
        check("hop", {got, seen.path_b, seen.index}, {2'b10, 32'hF});
        rd_chk("events", ADDR_IRQ, 32'h1);
        for (int i = 0; i < 3; i++) begin
            hop(frame(1'b0, 1'b0, bad_cmd[i], (i == 2) ? 32'h10 : 32'h2), 20);
            check("refused", got, 1'b0);
            rd_chk("events", ADDR_IRQ, (i == 2) ? 32'h4 : 32'h2);
        end
        rd_chk("index", ADDR_INDEX, 32'hF);
        apb(1'b1, ADDR_MASK, 32'h0);
        hop(frame(1'b0, 1'b0, 6'h03, 32'h1), 20);
        check("masked", irq, 1'b0);
        apb(1'b1, ADDR_MASK, 32'h2);
        @(negedge mclk);
        check("unmasked", irq, 1'b1);
        rd_chk("events", ADDR_IRQ, 32'h2);
        @(negedge mclk);
        check("cleared", irq, 1'b0);
        apb(1'b1, ADDR_CTRL, 32'h51);
        hop(frame(1'b0, 1'b1, CMD_LIST, 32'h3), 40);
        check("held", got, 1'b0);
        @(posedge mclk) instrument_trigger_a <= 1'b1;
        wait_apply(20);
        check("trig", {got, seen.path_b, seen.index}, {2'b10, 32'h3});
        @(posedge mclk) instrument_trigger_b <= 1'b1;
        apb(1'b1, ADDR_CTRL, 32'h151);
        hop(frame(1'b1, 1'b1, CMD_LIST, 32'h7), 40);
        check("held", got, 1'b0);
        @(posedge mclk) instrument_trigger_a <= 1'b0;
        wait_apply(20);
        check("other path", got, 1'b0);
        @(posedge mclk) instrument_trigger_b <= 1'b0;
        wait_apply(20);
        check("trig", {got, seen.path_b, seen.index}, {2'b11, 32'h7});
        apb(1'b1, ADDR_CTRL, 32'h62);
        repeat (3) @(negedge mclk);
        check("modes", {list_active, sweep_active}, 2'b01);
        hop(frame(1'b0, 1'b0, CMD_LIST, 32'h1), 20);
        check("sweep hop", got, 1'b0);
        apb(1'b1, ADDR_CTRL, 32'h1);
        wait_apply(20);
        check("walk", {got, list_active, sweep_active, seen.path_b, seen.index}, {4'b1100, 32'h0});
        wait_apply(20);
        check("walk", {got, seen.path_b, seen.index}, {2'b10, 32'h1});
        print_verdict();
    end
endmodule : tb_top

// ---- verilog/hop_receiver.sv ----
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module hop_receiver
    import hop_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        srst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Hop link pins
    input  wire logic        link_clk,
    input  wire logic        link_strobe,
    input  wire logic        link_data,
    // Instrument triggers
    input  wire logic        instrument_trigger_a,
    input  wire logic        instrument_trigger_b,
    // Applied setting
    output hop_apply_t       apply_q,
    output logic             list_active,
    output logic             sweep_active,
    // Interrupt
    output logic             irq
);

    localparam logic [31:0] LEARN_CYCLES = 32'h0000_0008;

    logic [31:0]        ctrl_q;
    logic [31:0]        len_q;
    logic [31:0]        dwell_q;
    logic [EV_W-1:0]    stat_q;
    logic [EV_W-1:0]    mask_q;
    logic               learned_q;
    logic [1:0]         trg_a_s_q;
    logic [1:0]         trg_b_s_q;
    logic               trg_a_q;
    logic               trg_b_q;
    logic               pend_q;
    logic               pend_path_q;
    logic [31:0]        pend_idx_q;
    logic [31:0]        cur_idx_q;
    logic [31:0]        dwell_cnt_q;
    logic               first_pass_q;
    logic               single_done_q;
    run_state_t         state_q;
    logic [FRAME_W-1:0] frame;
    logic               frame_v;

    hop_shift #(
        .WIDTH         (FRAME_W)
    ) u_shift (
        .mclk          (mclk),
        .srst          (srst),
        .link_clk      (link_clk),
        .link_strobe   (link_strobe),
        .link_data     (link_data),
        .frame_q       (frame),
        .frame_valid_q (frame_v)
    );

    // Frame fields
    hop_frame_t fr;
    assign fr = frame;
    wire        cmd_ok    = (fr.cmd == CMD_LIST);
    wire        idx_ok    = (fr.index < len_q);
    wire        hop_path  = fr.path_b;
    wire        hop_imm_n = fr.imm_n;
    wire [31:0] hop_idx   = fr.index;

    // Control fields
    list_mode_t mode;
    assign mode = list_mode_t'(ctrl_q[CTRL_MODE_LO +: 3]);
    wire trig_pol  = ctrl_q[CTRL_TRIG_POL];
    wire is_hop    = (mode == MODE_EXT_HOP) || (mode == MODE_EXT_HOP_DIRECT);
    wire running   = (state_q == ST_RUN);

    // Trigger edges; one polarity bit for both inputs
    wire trg_a_lvl = trg_a_s_q[1] ^ trig_pol;
    wire trg_b_lvl = trg_b_s_q[1] ^ trig_pol;
    wire trg_a_ev  = trg_a_lvl & ~trg_a_q;
    wire trg_b_ev  = trg_b_lvl & ~trg_b_q;
    wire trig_any  = trg_a_ev | trg_b_ev;

    // Held hop fires on the trigger of its own path
    wire pend_fire = pend_q & running & (pend_path_q ? trg_b_ev : trg_a_ev);

    // Frame acceptance
    wire frame_good = frame_v & cmd_ok & idx_ok & running & is_hop;
    wire direct_go  = frame_good & ~hop_imm_n;
    wire hold_go    = frame_good & hop_imm_n;

    // APB decode
    wire acc      = psel & penable;
    wire wr       = acc & pwrite;
    wire rd       = acc & ~pwrite;
    wire sel_ctrl = (paddr == ADDR_CTRL);
    wire sel_len  = (paddr == ADDR_LEN);
    wire sel_dw   = (paddr == ADDR_DWELL);
    wire sel_st   = (paddr == ADDR_STATUS);
    wire sel_irq  = (paddr == ADDR_IRQ);
    wire sel_mask = (paddr == ADDR_MASK);
    wire sel_idx  = (paddr == ADDR_INDEX);
    wire sel_lrn  = (paddr == ADDR_LEARN);
    wire mapped   = sel_ctrl | sel_len | sel_dw | sel_st | sel_irq | sel_mask | sel_idx | sel_lrn;
    wire ctrl_wr      = wr & sel_ctrl;
    wire ctrl_wr_step = ctrl_wr & pwdata[CTRL_STEP_GO];

    // Enabling one switches the other off; list wins a simultaneous write
    wire list_en_d  = ctrl_wr ? pwdata[CTRL_LIST_EN] : ctrl_q[CTRL_LIST_EN];
    wire sweep_en_d = ctrl_wr ? (pwdata[CTRL_SWEEP_EN] & ~pwdata[CTRL_LIST_EN]) :
                                ctrl_q[CTRL_SWEEP_EN];
    wire activate   = list_en_d & ~ctrl_q[CTRL_LIST_EN];
    wire restart    = ctrl_wr & pwdata[CTRL_RESTART];
    wire relearn    = ctrl_wr & pwdata[CTRL_LEARN];

    // Sequential walk stepping
    wire dwell_done = (dwell_cnt_q >= dwell_q);
    wire last_idx   = (cur_idx_q + 32'h0000_0001 >= len_q);
    wire seq_step   = running & ~is_hop & ~single_done_q &
                      (((mode == MODE_AUTO) || (mode == MODE_SINGLE) || (mode == MODE_EXT_SINGLE)) ? dwell_done :
                       (mode == MODE_STEP) ? ctrl_wr_step :
                       trig_any);
    wire [31:0] seq_next = last_idx ? 32'h0000_0000 : cur_idx_q + 32'h0000_0001;

    // Events
    wire [EV_W-1:0] ev;
    assign ev[EV_APPLY]   = direct_go | pend_fire | seq_step;
    assign ev[EV_BADCMD]  = frame_v & ~cmd_ok;
    assign ev[EV_RANGE]   = frame_v & cmd_ok & ~idx_ok;
    assign ev[EV_DWELL]   = (state_q == ST_LEARN) & first_pass_q & (dwell_q < LEARN_CYCLES);
    assign ev[EV_LEARNED] = (state_q == ST_LEARN);

    wire stat_rd = rd & sel_irq;
    wire [EV_W-1:0] stat_d = ev | (stat_q & ~({EV_W{stat_rd}}));              // Set wins over the read clear

    wire [31:0] status_word = {26'h0, learned_q, single_done_q, first_pass_q, pend_q,
                               (state_q == ST_LEARN), running};

    assign prdata = sel_ctrl ? ctrl_q :
                    sel_len  ? len_q :
                    sel_dw   ? dwell_q :
                    sel_st   ? status_word :
                    sel_irq  ? {{(32-EV_W){1'b0}}, stat_q} :
                    sel_mask ? {{(32-EV_W){1'b0}}, mask_q} :
                    sel_idx  ? apply_q.index :
                    sel_lrn  ? {31'h0, learned_q} : 32'h0000_0000;
    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;
    assign irq     = |(stat_q & mask_q);
    assign list_active  = ctrl_q[CTRL_LIST_EN];
    assign sweep_active = ctrl_q[CTRL_SWEEP_EN];

    // Registers
    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrl_q  <= '0;
            len_q   <= LEN_RESET;
            dwell_q <= DWELL_RESET;
            mask_q  <= '0;
            stat_q  <= '0;
        end else begin
            ctrl_q  <= ctrl_wr ? {pwdata[31:2], sweep_en_d, list_en_d} : ctrl_q;
            len_q   <= (wr & sel_len) ? pwdata : len_q;
            dwell_q <= (wr & sel_dw) ? pwdata : dwell_q;
            mask_q  <= (wr & sel_mask) ? pwdata[EV_W-1:0] : mask_q;
            stat_q  <= stat_d;
        end
    end

    // Trigger sampling
    always_ff @(posedge mclk) begin
        if (srst) begin
            trg_a_s_q <= '0;
            trg_b_s_q <= '0;
            trg_a_q   <= 1'b0;
            trg_b_q   <= 1'b0;
        end else begin
            trg_a_s_q <= {trg_a_s_q[0], instrument_trigger_a};
            trg_b_s_q <= {trg_b_s_q[0], instrument_trigger_b};
            trg_a_q   <= trg_a_lvl;
            trg_b_q   <= trg_b_lvl;
        end
    end

    // Run state: learn when no stored settings
    always_ff @(posedge mclk) begin
        if (srst) begin
            state_q      <= ST_IDLE;
            learned_q    <= 1'b0;
            first_pass_q <= 1'b0;
        end else begin
            if (wr & sel_len) begin
                learned_q <= 1'b0;
            end
            case (state_q)
                ST_IDLE: begin
                    if (activate) begin
                        state_q      <= (learned_q & ~relearn) ? ST_RUN : ST_LEARN;
                        first_pass_q <= ~learned_q | relearn;
                    end
                end
                ST_LEARN: begin
                    state_q   <= ST_RUN;
                    learned_q <= 1'b1;
                end
                ST_RUN: begin
                    if (~list_en_d) begin
                        state_q <= ST_IDLE;
                    end else if (relearn) begin
                        state_q      <= ST_LEARN;
                        first_pass_q <= 1'b1;
                    end else if (seq_step & last_idx) begin
                        first_pass_q <= 1'b0;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Index walk, hop hold and output
    always_ff @(posedge mclk) begin
        if (srst) begin
            pend_q        <= 1'b0;
            pend_path_q   <= 1'b0;
            pend_idx_q    <= '0;
            cur_idx_q     <= '0;
            dwell_cnt_q   <= '0;
            single_done_q <= 1'b0;
            apply_q       <= '0;
        end else begin
            apply_q.valid <= 1'b0;
            dwell_cnt_q   <= (seq_step | ~running) ? 32'h0000_0000 : dwell_cnt_q + 32'h0000_0001;
            if (~running | restart | activate) begin
                cur_idx_q     <= '0;
                single_done_q <= 1'b0;
                pend_q        <= pend_q & running & ~restart;
            end else if (direct_go) begin
                apply_q <= '{valid: 1'b1, path_b: hop_path, index: hop_idx};
                pend_q  <= 1'b0;
            end else if (hold_go) begin
                pend_q      <= 1'b1;
                pend_path_q <= hop_path;
                pend_idx_q  <= hop_idx;
            end else if (pend_fire) begin
                apply_q <= '{valid: 1'b1, path_b: pend_path_q, index: pend_idx_q};
                pend_q  <= 1'b0;
            end else if (seq_step) begin
                apply_q   <= '{valid: 1'b1, path_b: 1'b0, index: cur_idx_q};
                cur_idx_q <= seq_next;
                if (last_idx & (mode != MODE_AUTO) & (mode != MODE_STEP) & (mode != MODE_EXT_STEP)) begin
                    single_done_q <= 1'b1;
                end
            end
        end
    end

endmodule : hop_receiver

// ---- verilog/hop_shift.sv ----
`timescale 1ns/1ps
module hop_shift
    import hop_pkg::*;
#(
    parameter int unsigned WIDTH = FRAME_W
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             srst,
    // Raw link pins
    input  wire logic             link_clk,
    input  wire logic             link_strobe,
    input  wire logic             link_data,
    // Captured frame
    output logic [WIDTH-1:0]      frame_q,
    output logic                  frame_valid_q
);

    logic [2:0]       clk_s_q;
    logic [1:0]       stb_s_q;
    logic [1:0]       dat_s_q;
    logic [WIDTH-1:0] shift_q;
    wire              rise;
    wire [WIDTH-1:0]  shift_d;

    // Data and strobe take the same two stages so they stay aligned to the clock edge
    assign rise    = clk_s_q[1] & ~clk_s_q[2];
    assign shift_d = {shift_q[WIDTH-2:0], dat_s_q[1]};

    always_ff @(posedge mclk) begin
        if (srst) begin
            clk_s_q       <= '0;
            stb_s_q       <= '0;
            dat_s_q       <= '0;
            shift_q       <= '0;
            frame_q       <= '0;
            frame_valid_q <= 1'b0;
        end else begin
            clk_s_q       <= {clk_s_q[1:0], link_clk};
            stb_s_q       <= {stb_s_q[0], link_strobe};
            dat_s_q       <= {dat_s_q[0], link_data};
            frame_valid_q <= 1'b0;
            if (rise) begin
                shift_q <= shift_d;
                if (stb_s_q[1]) begin
                    frame_q       <= shift_d;
                    frame_valid_q <= 1'b1;
                end
            end
        end
    end

endmodule : hop_shift
